// ---- core/mrc_pkg.sv ----
// Package of the reset controller: constants, option encodings and carrier types.
// Assumes a single 10 MHz system clock domain.
package mrc_pkg;
    localparam int unsigned CLK_PERIOD_NS       = 100;
    localparam int unsigned POWER_ON_DELAY_MS   = 100;
    localparam int unsigned POWER_ON_DELAY_CYC  =
        (POWER_ON_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LV_MIN_DURATION_NS  = 1000;
    localparam int unsigned LV_MIN_CYC          =
        (LV_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STARTUP_LONG_CYC    = 1024;
    localparam int unsigned STARTUP_SHORT_CYC   = 2;
    localparam int unsigned CNT_W               = 24;

    localparam logic [7:0] CONTROL_REG_ONE_INIT  = 8'h8a;
    localparam logic [7:0] CONVERTER_CONTROL_REG_INIT   = 8'h40;
    localparam logic [7:0] PORT_DIR_IN = 8'hff;
    localparam logic [2:0] STACK_TOP   = 3'h0;
    localparam logic [7:0] PC_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        MRC_SRC_FAST_XTAL = 2'h0,
        MRC_SRC_SLOW_XTAL = 2'h1,
        MRC_SRC_EXT_RC    = 2'h2,
        MRC_SRC_INT_RC    = 2'h3
    } mrc_osc_t;

    // Gray codes along delay, start-up and run, so each step flips one bit.
    typedef enum logic [1:0] {
        MRC_RUN   = 2'h2,
        MRC_DELAY = 2'h1,
        MRC_START = 2'h3
    } mrc_state_t;

    typedef enum logic [2:0] {
        MRC_KIND_NONE  = 3'h0,
        MRC_KIND_POR   = 3'h1,
        MRC_KIND_PIN   = 3'h2,
        MRC_KIND_LV    = 3'h3,
        MRC_KIND_WDT   = 3'h4,
        MRC_KIND_WAKE  = 3'h5
    } mrc_kind_t;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } mrc_flags_t;

    typedef struct packed {
        logic [7:0] control_reg_one;
        logic [7:0] converter_control_reg;
        logic [7:0] port_dir;
        logic [7:0] program_counter_low;
        logic [2:0] stack_ptr;
    } mrc_init_t;
endpackage : mrc_pkg

// ---- core/mrc_lv_filter.sv ----
// Low-supply glitch filter: reports a low-voltage event only after persistence.
// Assumes the supply monitor level is synchronous to sys_clk.
`timescale 1ns/1ps
module mrc_lv_filter
    import mrc_pkg::*;
#(
    parameter int unsigned MIN_CYC = LV_MIN_CYC
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic enable,
    input  wire logic supply_low,
    output logic      lv_trip
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        trip;
    } mrc_lvf_t;

    mrc_lvf_t st;
    mrc_lvf_t next_st;

    // =====================================================================
    // Persistence counter
    always_comb begin
        next_st = st;
        if (!enable || !supply_low) begin
            next_st.cnt  = 16'h0000;
            next_st.trip = 1'b0;
        end else if (st.cnt >= 16'(MIN_CYC)) begin
            next_st.trip = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lv_trip = st.trip;

    chk_lv_persist: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(lv_trip) |-> $past(supply_low) && $past(enable))
        else $error("low-voltage trip without sustained low supply");
endmodule : mrc_lv_filter

// ---- core/mrc_reset_ctrl.sv ----
// Reset controller: merges power-on, pin, low-voltage and watchdog resets.
// Assumes all inputs except arst_n are synchronous to sys_clk; arst_n is the asynchronous power-on reset.
`timescale 1ns/1ps
module mrc_reset_ctrl
    import mrc_pkg::*;
#(
    parameter int unsigned POR_DELAY_CYC = POWER_ON_DELAY_CYC,
    parameter int unsigned LV_CYC        = LV_MIN_CYC
) (
    input  wire logic      sys_clk,
    input  wire logic      arst_n,
    input  wire logic      reset_pin_n,
    input  wire logic      supply_low,
    input  wire logic      lvr_enable,
    input  wire logic [1:0] lvr_level_sel,
    input  wire mrc_osc_t  osc_source,
    input  wire logic      short_startup,
    input  wire logic      wdt_timeout,
    input  wire logic      sleeping,
    input  wire logic      sleep_entry,
    input  wire logic      wdt_clear,
    output logic           core_reset,
    output logic           peri_reset,
    output logic           wake,
    output logic           pc_sp_clear,
    output logic           wdt_restart,
    output logic           int_disable,
    output logic           timer_off,
    output logic [1:0]     lvr_level,
    output mrc_flags_t     flags,
    output mrc_init_t      init_vals,
    output logic           init_load
);
    typedef struct packed {
        mrc_state_t  state;
        logic [CNT_W-1:0] cnt;
        mrc_flags_t  flags;
        mrc_kind_t   kind;
        logic        core_rst;
        logic        peri_rst;
        logic        wake;
        logic        pc_sp;
        logic        wdt_rst;
        logic        load;
        mrc_init_t   init;
    } mrc_st_t;

    mrc_st_t st;
    mrc_st_t next_st;
    logic    lv_trip;
    logic    pin_low;
    logic [CNT_W-1:0] sst_len;

    // =====================================================================
    // Low-voltage detector
    mrc_lv_filter #(.MIN_CYC(LV_CYC)) u_lvf (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .enable     (lvr_enable),
        .supply_low (supply_low),
        .lv_trip    (lv_trip)
    );

    assign lvr_level = lvr_enable ? lvr_level_sel : 2'h0;

    // pin held low by outside hardware
    assign pin_low = !reset_pin_n;

    // =====================================================================
    // Start-up timer length
    always_comb begin
        if (short_startup &&
            (osc_source == MRC_SRC_EXT_RC || osc_source == MRC_SRC_INT_RC)) begin
            sst_len = CNT_W'(STARTUP_SHORT_CYC);
        end else begin
            sst_len = CNT_W'(STARTUP_LONG_CYC);
        end
    end

    // =====================================================================
    // Sequencer
    always_comb begin
        next_st       = st;
        next_st.wake  = 1'b0;
        next_st.pc_sp = 1'b0;
        next_st.load  = 1'b0;
        // sleep entry and watchdog clear move the flags
        if (sleep_entry) begin
            next_st.flags.powerdown_flag = 1'b1;
            next_st.flags.timeout_flag   = 1'b0;
        end else if (wdt_clear) begin
            next_st.flags = '0;
        end
        if (pin_low || lv_trip) begin
            next_st.kind     = pin_low ? MRC_KIND_PIN : MRC_KIND_LV;
            next_st.state    = MRC_DELAY;
            next_st.cnt      = '0;
            next_st.core_rst = 1'b1;
            next_st.peri_rst = 1'b1;
            next_st.wdt_rst  = 1'b1;
            next_st.load     = 1'b1;
        end else if (wdt_timeout && sleeping) begin
            next_st.kind                 = MRC_KIND_WAKE;
            next_st.flags.timeout_flag   = 1'b1;
            next_st.flags.powerdown_flag = 1'b1;
            next_st.pc_sp                = 1'b1;
            next_st.wake                 = 1'b1;
            next_st.state                = MRC_START;
            next_st.cnt                  = '0;
            next_st.core_rst             = 1'b1;
        end else if (wdt_timeout) begin
            // like pin reset plus flag, but straight to start-up without the power-on delay
            next_st.kind               = MRC_KIND_WDT;
            next_st.flags.timeout_flag = 1'b1;
            next_st.state              = MRC_START;
            next_st.cnt                = '0;
            next_st.core_rst           = 1'b1;
            next_st.peri_rst           = 1'b1;
            next_st.wdt_rst            = 1'b1;
            next_st.load               = 1'b1;
        end else begin
            case (st.state)
                MRC_DELAY: begin
                    // power-on delay after por, pin or lv
                    if (st.cnt >= CNT_W'(POR_DELAY_CYC - 1)) begin
                        next_st.state = MRC_START;
                        next_st.cnt   = '0;
                    end else begin
                        next_st.cnt = st.cnt + 1'b1;
                    end
                end
                MRC_START: begin
                    if (st.cnt >= sst_len - 1'b1) begin
                        next_st.state    = MRC_RUN;
                        next_st.core_rst = 1'b0;
                        next_st.peri_rst = 1'b0;
                        next_st.wdt_rst  = 1'b0;
                        next_st.kind     = MRC_KIND_NONE;
                    end else begin
                        next_st.cnt = st.cnt + 1'b1;
                    end
                end
                default: begin
                    next_st.state = MRC_RUN;
                end
            endcase
        end
        // same initial values for every loading reset type, sleep wake keeps them
        if (next_st.load) begin
            next_st.init.control_reg_one       = CONTROL_REG_ONE_INIT;
            next_st.init.converter_control_reg = CONVERTER_CONTROL_REG_INIT;
            next_st.init.port_dir              = PORT_DIR_IN;
            next_st.init.program_counter_low   = PC_ZERO;
            next_st.init.stack_ptr             = STACK_TOP;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st                            <= '0;
            st.state                      <= MRC_DELAY;
            st.kind                       <= MRC_KIND_POR;
            st.core_rst                   <= 1'b1;
            st.peri_rst                   <= 1'b1;
            st.wdt_rst                    <= 1'b1;
            st.load                       <= 1'b1;
            st.init.control_reg_one       <= CONTROL_REG_ONE_INIT;
            st.init.converter_control_reg <= CONVERTER_CONTROL_REG_INIT;
            st.init.port_dir              <= PORT_DIR_IN;
            st.init.program_counter_low   <= PC_ZERO;
            st.init.stack_ptr             <= STACK_TOP;
        end else begin
            st <= next_st;
        end
    end

    // =====================================================================
    // Outputs
    assign core_reset  = st.core_rst;
    assign peri_reset  = st.peri_rst;
    assign wake        = st.wake;
    assign pc_sp_clear = st.pc_sp;
    assign wdt_restart = st.wdt_rst;
    assign int_disable = st.peri_rst;
    assign timer_off   = st.peri_rst;
    assign flags       = st.flags;
    assign init_vals   = st.init;
    assign init_load   = st.load;

    // =====================================================================
    // Checks
    chk_wdt_run_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wdt_timeout && !sleeping && reset_pin_n && !lv_trip)
        |=> flags.timeout_flag && core_reset && init_load)
        else $error("running timeout did not reset with flag");
    chk_sleep_wake: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wdt_timeout && sleeping && reset_pin_n && !lv_trip)
        |=> pc_sp_clear && wake && !init_load && !peri_reset)
        else $error("sleep timeout touched more than pc and sp");
    chk_sleep_flags: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wdt_timeout && sleeping && reset_pin_n && !lv_trip)
        |=> flags == 2'b11)
        else $error("sleep timeout flags wrong");
    chk_pin_keeps: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!reset_pin_n && !sleep_entry && !wdt_clear) |=> $stable(flags))
        else $error("pin reset changed flags");
    chk_startup_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wdt_timeout && !sleeping && reset_pin_n && !lv_trip) ##1
        (!wdt_timeout && reset_pin_n && !lv_trip)[*3] |->
        (short_startup && osc_source[1]) ? !core_reset : core_reset)
        else $error("start-up timer length wrong");
    chk_sleep_pdf: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (sleep_entry && !wdt_timeout) |=> flags.powerdown_flag)
        else $error("sleep entry did not set power-down flag");
    chk_pin_delay: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(reset_pin_n) |-> core_reset[*8])
        else $error("pin reset released without delay");
    chk_init_vals: assert property (@(posedge sys_clk) disable iff (!arst_n)
        init_load |-> init_vals.control_reg_one == CONTROL_REG_ONE_INIT
                   && init_vals.port_dir == PORT_DIR_IN)
        else $error("initial values wrong");
    chk_rst_ties: assert property (@(posedge sys_clk) disable iff (!arst_n)
        peri_reset |-> wdt_restart && core_reset)
        else $error("watchdog not held in reset");

    cov_pin_reset:  cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(reset_pin_n));
    cov_sleep_wake: cover property (@(posedge sys_clk) disable iff (!arst_n) wake);
    cov_release:    cover property (@(posedge sys_clk) disable iff (!arst_n) $fell(core_reset));
    cov_lv_trip:    cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(lv_trip));
endmodule : mrc_reset_ctrl

// ---- dv/mrc_partner.sv ----
// Far-side model: reset pin circuitry, supply monitor and watchdog pulses.
// Assumes one bench process calls its tasks; every change lands by NBA at a sys_clk edge.
`timescale 1ns/1ps
module mrc_partner (
    input  wire logic sys_clk,
    output logic      reset_pin_n,
    output logic      supply_low,
    output logic      wdt_timeout,
    output logic      sleeping,
    output logic      sleep_entry,
    output logic      wdt_clear
);
    // ==========================================================
    // Idle levels
    initial begin
        reset_pin_n = 1'b1;
        supply_low  = 1'b0;
        wdt_timeout = 1'b0;
        sleeping    = 1'b0;
        sleep_entry = 1'b0;
        wdt_clear   = 1'b0;
    end

    // ==========================================================
    // Stimulus tasks
    // pin pulled low
    task automatic pin_reset(input int unsigned n);
        @(posedge sys_clk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
    endtask : pin_reset

    task automatic low_supply(input int unsigned n);
        @(posedge sys_clk);
        supply_low <= 1'b1;
        repeat (n) @(posedge sys_clk);
        supply_low <= 1'b0;
    endtask : low_supply

    task automatic set_sleep(input logic s);
        @(posedge sys_clk);
        sleeping <= s;
    endtask : set_sleep

    // One-cycle pulse: 0 watchdog time-out, 1 sleep entry, else clear-watchdog.
    task automatic pulse(input int unsigned which);
        @(posedge sys_clk);
        case (which)
            0: wdt_timeout <= 1'b1;
            1: sleep_entry <= 1'b1;
            default: wdt_clear <= 1'b1;
        endcase
        @(posedge sys_clk);
        wdt_timeout <= 1'b0;
        sleep_entry <= 1'b0;
        wdt_clear   <= 1'b0;
    endtask : pulse
endmodule : mrc_partner

// ---- dv/mcu_reset_controller_tb.sv ----
// Self-checking bench of the reset controller with a shortened power-on delay.
// Assumes mrc_pkg, the design files and mrc_partner are compiled first.
`timescale 1ns/1ps
module mcu_reset_controller_tb
    import mrc_pkg::*;
;
    localparam int unsigned POR_CYC  = 20;
    localparam int unsigned LV_CYC   = LV_MIN_CYC;
    localparam mrc_init_t   INIT_EXP = '{CONTROL_REG_ONE_INIT, CONVERTER_CONTROL_REG_INIT, PORT_DIR_IN, PC_ZERO, STACK_TOP};

    logic       sys_clk, arst_n, lvr_enable, short_startup;
    logic [1:0] lvr_level_sel, lvr_level;
    mrc_osc_t   osc_source;
    logic       reset_pin_n, supply_low, wdt_timeout, sleeping, sleep_entry, wdt_clear;
    logic       core_reset, peri_reset, wake, pc_sp_clear, wdt_restart, int_disable, timer_off;
    logic       init_load;
    mrc_flags_t flags;
    mrc_init_t  init_vals;
    int         n_fail, check_count;

    // ==========================================================
    // Instances
    mrc_partner mrc_partner_inst (.sys_clk(sys_clk), .reset_pin_n(reset_pin_n),
        .supply_low(supply_low), .wdt_timeout(wdt_timeout), .sleeping(sleeping),
        .sleep_entry(sleep_entry), .wdt_clear(wdt_clear));

    mrc_reset_ctrl #(.POR_DELAY_CYC(POR_CYC), .LV_CYC(LV_CYC)) mrc_reset_ctrl_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .reset_pin_n(reset_pin_n),
        .supply_low(supply_low), .lvr_enable(lvr_enable), .lvr_level_sel(lvr_level_sel),
        .osc_source(osc_source), .short_startup(short_startup), .wdt_timeout(wdt_timeout),
        .sleeping(sleeping), .sleep_entry(sleep_entry), .wdt_clear(wdt_clear),
        .core_reset(core_reset), .peri_reset(peri_reset), .wake(wake),
        .pc_sp_clear(pc_sp_clear), .wdt_restart(wdt_restart), .int_disable(int_disable),
        .timer_off(timer_off), .lvr_level(lvr_level), .flags(flags),
        .init_vals(init_vals), .init_load(init_load));

    // ==========================================================
    // Clock, checks and closing
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Counts edges until the core leaves reset; the exact edge of release is the design's.
    task automatic wait_release(input int unsigned exp, input string what);
        int unsigned cnt;
        #1;
        cnt = 0;
        while (core_reset !== 1'b0 && cnt < 3000) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        check(40'(cnt >= exp - 1 && cnt <= exp + 4), 40'h1, what);
    endtask : wait_release

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        #(30000 * 100);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end

    // ==========================================================
    // Test sequence
    initial begin
        n_fail = 0;
        check_count = 0;
        arst_n = 1'b0;
        lvr_enable = 1'b1;
        lvr_level_sel = 2'h2;
        osc_source = MRC_SRC_INT_RC;
        short_startup = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        check(40'(flags), 40'h0, "power-on flags");
        check(40'(init_vals), 40'(INIT_EXP), "power-on values");
        check(40'({core_reset, peri_reset, wdt_restart, init_load}), 40'hf, "hold");
        check(40'({int_disable, timer_off}), 40'h3, "irq and timers off");
        check(40'(lvr_level), 40'h2, "level select");
        @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_release(POR_CYC + STARTUP_SHORT_CYC, "power-on release");
        check(40'({peri_reset, wdt_restart, int_disable, timer_off, init_load}), 40'h0,
              "released");
        mrc_partner_inst.pulse(0);
        #1;
        check(40'({core_reset, peri_reset, init_load}), 40'h7, "run timeout reset");
        check(40'(flags), 40'h2, "run timeout flags");
        check(40'(init_vals), 40'(INIT_EXP), "run timeout values");
        wait_release(STARTUP_SHORT_CYC, "short start-up");
        @(posedge sys_clk);
        osc_source <= MRC_SRC_FAST_XTAL;
        mrc_partner_inst.pulse(0);
        wait_release(STARTUP_LONG_CYC, "crystal start-up");
        @(posedge sys_clk);
        osc_source <= MRC_SRC_EXT_RC;
        short_startup <= 1'b0;
        lvr_level_sel <= 2'h1;
        mrc_partner_inst.pulse(0);
        wait_release(STARTUP_LONG_CYC, "rc long start-up");
        check(40'(lvr_level), 40'h1, "level reselect");
        @(posedge sys_clk);
        short_startup <= 1'b1;
        mrc_partner_inst.pulse(1);
        #1;
        check(40'(flags), 40'h1, "sleep entry flags");
        mrc_partner_inst.pulse(2);
        #1;
        check(40'(flags), 40'h0, "clear flags");
        mrc_partner_inst.set_sleep(1'b1);
        mrc_partner_inst.pulse(0);
        #1;
        check(40'({wake, pc_sp_clear, core_reset}), 40'h7, "sleep wake");
        check(40'({peri_reset, init_load}), 40'h0, "sleep keeps regs");
        check(40'(flags), 40'h3, "sleep timeout flags");
        wait_release(STARTUP_SHORT_CYC, "wake release");
        mrc_partner_inst.set_sleep(1'b0);
        mrc_partner_inst.pin_reset(5);
        #1;
        check(40'({core_reset, peri_reset}), 40'h3, "pin reset");
        check(40'(flags), 40'h3, "pin keeps flags");
        wait_release(POR_CYC + STARTUP_SHORT_CYC, "pin release");
        mrc_partner_inst.low_supply(LV_CYC);
        repeat (4) @(posedge sys_clk);
        #1;
        check(40'(core_reset), 40'h0, "short dip ignored");
        mrc_partner_inst.low_supply(LV_CYC + 2);
        #1;
        check(40'(core_reset), 40'h1, "long dip resets");
        check(40'(flags), 40'h3, "dip keeps flags");
        wait_release(POR_CYC + STARTUP_SHORT_CYC, "dip release");
        @(posedge sys_clk);
        lvr_enable <= 1'b0;
        mrc_partner_inst.low_supply(LV_CYC + 4);
        #1;
        check(40'({core_reset, lvr_level}), 40'h0, "option off");
        @(posedge sys_clk);
        #30;
        arst_n = 1'b0;
        #1;
        check(40'({core_reset, flags}), 40'h4, "async assert");
        @(posedge sys_clk);
        arst_n <= 1'b1;
        wait_release(POR_CYC + STARTUP_SHORT_CYC, "second power-on");
        test_done();
    end
endmodule : mcu_reset_controller_tb
